/* File: hdl/hbd_pkg.sv */
// Constants, types and inversion helpers shared by both ends of the data phase link.
// Assumes one core clock per end; the hub end makes the bus clock, the cpu end samples it.
// Contract
// [RULE_01] Driver holds busy low while occupying bus
// [RULE_02] Bus free only after busy deasserted
// [RULE_03] Out-of-order flag means processor accepts later completion
// [RULE_04] Addressed hub agent drives out-of-order flag
// [RULE_05] One polarity flag per 16-line group
// [RULE_06] Flag active only when group inverted
// [RULE_07] Invert decision from group toggle count
// [RULE_08] Whole group inverted together, never bits
// [RULE_09] Invert when more than eight lines toggle
package hbd_pkg;

  localparam int DATA_W        = 64;
  localparam int GROUP_W       = 16;
  localparam int GROUPS        = 4;
  localparam int TOGGLE_LIMIT  = 8;
  localparam int CORE_CLK_NS   = 100;
  localparam int BUS_CLK_NS    = 800;
  localparam int HALF_DIV      = BUS_CLK_NS / (2 * CORE_CLK_NS);
  localparam int DIV_W         = 4;
  localparam int SYNC_W        = DATA_W + GROUPS + 4;

  localparam logic [DATA_W-1:0] BUS_IDLE  = 64'hffff_ffff_ffff_ffff;
  localparam logic [GROUPS-1:0] FLAG_IDLE = 4'hf;
  localparam logic [DIV_W-1:0]  DIV_LAST  = DIV_W'(HALF_DIV - 1);
  localparam logic [DIV_W-1:0]  DIV_ZERO  = 4'h0;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_DRIVE = 2'b10
  } hbd_state_type;

  // Groups whose lines would toggle too often against the last driven levels
  function automatic logic [GROUPS-1:0] hbd_invert_mask(input logic [DATA_W-1:0] prev,
                                                        input logic [DATA_W-1:0] data);
    logic [DATA_W-1:0] diff;
    logic [4:0]        cnt;
    logic [GROUPS-1:0] inv;
    diff = prev ^ data;
    inv  = '0;
    for (int g = 0; g < GROUPS; g++) begin
      cnt = '0;
      for (int b = 0; b < GROUP_W; b++) begin
        cnt = cnt + 5'(diff[g*GROUP_W+b]);
      end
      inv[g] = (cnt > 5'(TOGGLE_LIMIT)); // RULE_07 RULE_09
    end
    return inv;
  endfunction : hbd_invert_mask

  // Spread one bit per group over all its lines
  function automatic logic [DATA_W-1:0] hbd_expand(input logic [GROUPS-1:0] inv);
    logic [DATA_W-1:0] m;
    for (int g = 0; g < GROUPS; g++) begin
      m[g*GROUP_W +: GROUP_W] = {GROUP_W{inv[g]}}; // RULE_05 RULE_08
    end
    return m;
  endfunction : hbd_expand

endpackage : hbd_pkg

/* File: hdl/hbd_link_if.sv */
// Shared bus wires between processor end and hub end.
// Resolves open-drain busy and two-way data and flags from each end's enables; idle level is high.
interface hbd_link_if;
  import hbd_pkg::*;

  logic                 bus_clk;
  logic                 occ_cpu_o;
  logic                 occ_cpu_oe;
  logic                 occ_hub_o;
  logic                 occ_hub_oe;
  logic                 data_bus_occupied_n;
  logic [DATA_W-1:0]    dat_cpu_o;
  logic                 dat_cpu_oe;
  logic [DATA_W-1:0]    dat_hub_o;
  logic                 dat_hub_oe;
  logic [DATA_W-1:0]    data_line;
  logic [GROUPS-1:0]    pol_cpu_o;
  logic [GROUPS-1:0]    pol_hub_o;
  logic [GROUPS-1:0]    group_polarity_flag_n;
  logic                 cpu_valid_n;
  logic                 hub_valid_n;
  logic                 out_of_order_flag_n;

  assign data_bus_occupied_n   = ~((occ_cpu_oe & ~occ_cpu_o) | (occ_hub_oe & ~occ_hub_o));
  assign data_line             = dat_cpu_oe ? dat_cpu_o : (dat_hub_oe ? dat_hub_o : BUS_IDLE);
  assign group_polarity_flag_n = dat_cpu_oe ? pol_cpu_o : (dat_hub_oe ? pol_hub_o : FLAG_IDLE);

  modport cpu (input bus_clk, data_bus_occupied_n, data_line, group_polarity_flag_n, hub_valid_n,
               input out_of_order_flag_n,
               output occ_cpu_o, occ_cpu_oe, dat_cpu_o, dat_cpu_oe, pol_cpu_o, cpu_valid_n);
  modport hub (input data_bus_occupied_n, data_line, group_polarity_flag_n, cpu_valid_n,
               output bus_clk, out_of_order_flag_n,
               output occ_hub_o, occ_hub_oe, dat_hub_o, dat_hub_oe, pol_hub_o, hub_valid_n);
endinterface : hbd_link_if

/* File: hdl/hbd_cpu_end.sv */
// Processor end of the data phase: drives words with group inversion, receives hub words,
// records out-of-order indications. Samples the bus clock made by the hub end.
module hbd_cpu_end (
  input  wire logic                    core_clk,
  input  wire logic                    nrst,
  hbd_link_if.cpu                      link,
  input  wire logic                    tx_valid,
  input  wire logic [hbd_pkg::DATA_W-1:0] tx_data,
  output logic                         tx_taken,
  output logic                         rx_valid,
  output logic [hbd_pkg::DATA_W-1:0]   rx_data,
  output logic                         deferred,
  output logic                         deferred_pending
);
  import hbd_pkg::*;

  logic [SYNC_W-1:0]  sync1_reg;
  logic [SYNC_W-1:0]  sync2_reg;
  logic               clk_prev_reg;
  hbd_state_type      state_reg,   state_next;
  logic [DATA_W-1:0]  prev_reg,    prev_next;
  logic               occ_oe_reg,  occ_oe_next;
  logic [DATA_W-1:0]  dat_o_reg,   dat_o_next;
  logic               dat_oe_reg,  dat_oe_next;
  logic [GROUPS-1:0]  pol_o_reg,   pol_o_next;
  logic               valid_n_reg, valid_n_next;
  logic               taken_reg,   taken_next;
  logic               rxv_reg,     rxv_next;
  logic [DATA_W-1:0]  rxd_reg,     rxd_next;
  logic               def_reg,     def_next;
  logic               pend_reg,    pend_next;
  logic               tick;
  logic               occ_free;
  logic               ooo_seen;
  logic               hub_word;
  logic [GROUPS-1:0]  pol_s;
  logic [DATA_W-1:0]  dat_s;
  logic [GROUPS-1:0]  inv;

  assign tick     = sync2_reg[SYNC_W-1] & ~clk_prev_reg;
  assign occ_free = sync2_reg[SYNC_W-2];
  assign ooo_seen = ~sync2_reg[SYNC_W-3];
  assign hub_word = ~sync2_reg[SYNC_W-4];
  assign pol_s    = sync2_reg[DATA_W +: GROUPS];
  assign dat_s    = sync2_reg[DATA_W-1:0];
  assign inv      = hbd_invert_mask(prev_reg, tx_data); // RULE_07 RULE_09

  always_comb begin
    state_next   = state_reg;
    prev_next    = prev_reg;
    occ_oe_next  = occ_oe_reg;
    dat_o_next   = dat_o_reg;
    dat_oe_next  = dat_oe_reg;
    pol_o_next   = pol_o_reg;
    valid_n_next = valid_n_reg;
    taken_next   = 1'b0;
    rxv_next     = 1'b0;
    rxd_next     = rxd_reg;
    def_next     = 1'b0;
    pend_next    = pend_reg;
    if (tick) begin
      case (state_reg)
        ST_IDLE: begin
          if (tx_valid && occ_free) begin // RULE_02
            state_next = ST_DRIVE;
          end
        end
        ST_DRIVE: begin
          if (!tx_valid) begin
            state_next = ST_IDLE;
          end
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
      if (tx_valid && (state_reg == ST_DRIVE || occ_free)) begin
        occ_oe_next  = 1'b1; // RULE_01
        dat_oe_next  = 1'b1;
        dat_o_next   = tx_data ^ hbd_expand(inv); // RULE_08
        prev_next    = tx_data ^ hbd_expand(inv);
        pol_o_next   = ~inv; // RULE_06
        valid_n_next = 1'b0;
        taken_next   = 1'b1;
      end else begin
        occ_oe_next  = 1'b0; // RULE_01
        dat_oe_next  = 1'b0;
        dat_o_next   = BUS_IDLE;
        prev_next    = BUS_IDLE;
        pol_o_next   = FLAG_IDLE;
        valid_n_next = 1'b1;
      end
      if (hub_word) begin
        rxv_next = 1'b1;
        rxd_next = dat_s ^ hbd_expand(~pol_s); // RULE_05
        pend_next = 1'b0;
      end
      if (ooo_seen) begin
        def_next  = 1'b1; // RULE_03
        pend_next = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sync1_reg    <= '1;
      sync2_reg    <= '1;
      clk_prev_reg <= 1'b1;
      state_reg    <= ST_IDLE;
      prev_reg     <= BUS_IDLE;
      occ_oe_reg   <= 1'b0;
      dat_o_reg    <= BUS_IDLE;
      dat_oe_reg   <= 1'b0;
      pol_o_reg    <= FLAG_IDLE;
      valid_n_reg  <= 1'b1;
      taken_reg    <= 1'b0;
      rxv_reg      <= 1'b0;
      rxd_reg      <= '0;
      def_reg      <= 1'b0;
      pend_reg     <= 1'b0;
    end else begin
      sync1_reg    <= {link.bus_clk, link.data_bus_occupied_n, link.out_of_order_flag_n, link.hub_valid_n,
                       link.group_polarity_flag_n, link.data_line};
      sync2_reg    <= sync1_reg;
      clk_prev_reg <= sync2_reg[SYNC_W-1];
      state_reg    <= state_next;
      prev_reg     <= prev_next;
      occ_oe_reg   <= occ_oe_next;
      dat_o_reg    <= dat_o_next;
      dat_oe_reg   <= dat_oe_next;
      pol_o_reg    <= pol_o_next;
      valid_n_reg  <= valid_n_next;
      taken_reg    <= taken_next;
      rxv_reg      <= rxv_next;
      rxd_reg      <= rxd_next;
      def_reg      <= def_next;
      pend_reg     <= pend_next;
    end
  end

  assign link.occ_cpu_o   = 1'b0;
  assign link.occ_cpu_oe  = occ_oe_reg;
  assign link.dat_cpu_o   = dat_o_reg;
  assign link.dat_cpu_oe  = dat_oe_reg;
  assign link.pol_cpu_o   = pol_o_reg;
  assign link.cpu_valid_n = valid_n_reg;
  assign tx_taken         = taken_reg;
  assign rx_valid         = rxv_reg;
  assign rx_data          = rxd_reg;
  assign deferred         = def_reg;
  assign deferred_pending = pend_reg;

endmodule : hbd_cpu_end

/* File: hdl/hbd_hub_end.sv */
// Hub end of the data phase: makes the bus clock, drives words with group inversion,
// receives processor words and drives the out-of-order flag on request.
module hbd_hub_end (
  input  wire logic                    core_clk,
  input  wire logic                    nrst,
  hbd_link_if.hub                      link,
  input  wire logic                    tx_valid,
  input  wire logic [hbd_pkg::DATA_W-1:0] tx_data,
  output logic                         tx_taken,
  input  wire logic                    out_of_order_flag_n_req,
  output logic                         out_of_order_flag_n_taken,
  output logic                         rx_valid,
  output logic [hbd_pkg::DATA_W-1:0]   rx_data
);
  import hbd_pkg::*;

  logic [SYNC_W-3:0]  sync1_reg;
  logic [SYNC_W-3:0]  sync2_reg;
  logic [DIV_W-1:0]   div_reg,     div_next;
  logic               bclk_reg,    bclk_next;
  hbd_state_type      state_reg,   state_next;
  logic [DATA_W-1:0]  prev_reg,    prev_next;
  logic               occ_oe_reg,  occ_oe_next;
  logic [DATA_W-1:0]  dat_o_reg,   dat_o_next;
  logic               dat_oe_reg,  dat_oe_next;
  logic [GROUPS-1:0]  pol_o_reg,   pol_o_next;
  logic               valid_n_reg, valid_n_next;
  logic               ooo_n_reg,   ooo_n_next;
  logic               taken_reg,   taken_next;
  logic               dtak_reg,    dtak_next;
  logic               rxv_reg,     rxv_next;
  logic [DATA_W-1:0]  rxd_reg,     rxd_next;
  logic               sync3_occ_reg;
  logic               tick;
  logic               occ_free;
  logic               cpu_word;
  logic [GROUPS-1:0]  pol_s;
  logic [DATA_W-1:0]  dat_s;
  logic [GROUPS-1:0]  inv;

  assign tick     = (div_reg == DIV_LAST) & ~bclk_reg;
  assign occ_free = sync3_occ_reg;
  assign cpu_word = ~sync2_reg[SYNC_W-4];
  assign pol_s    = sync2_reg[DATA_W +: GROUPS];
  assign dat_s    = sync2_reg[DATA_W-1:0];
  assign inv      = hbd_invert_mask(prev_reg, tx_data); // RULE_07 RULE_09

  always_comb begin
    div_next     = (div_reg == DIV_LAST) ? DIV_ZERO : div_reg + 4'h1;
    bclk_next    = (div_reg == DIV_LAST) ? ~bclk_reg : bclk_reg;
    state_next   = state_reg;
    prev_next    = prev_reg;
    occ_oe_next  = occ_oe_reg;
    dat_o_next   = dat_o_reg;
    dat_oe_next  = dat_oe_reg;
    pol_o_next   = pol_o_reg;
    valid_n_next = valid_n_reg;
    ooo_n_next   = ooo_n_reg;
    taken_next   = 1'b0;
    dtak_next    = 1'b0;
    rxv_next     = 1'b0;
    rxd_next     = rxd_reg;
    if (tick) begin
      case (state_reg)
        ST_IDLE: begin
          if (tx_valid && occ_free) begin // RULE_02
            state_next = ST_DRIVE;
          end
        end
        ST_DRIVE: begin
          if (!tx_valid) begin
            state_next = ST_IDLE;
          end
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
      if (tx_valid && (state_reg == ST_DRIVE || occ_free)) begin
        occ_oe_next  = 1'b1; // RULE_01
        dat_oe_next  = 1'b1;
        dat_o_next   = tx_data ^ hbd_expand(inv); // RULE_08
        prev_next    = tx_data ^ hbd_expand(inv);
        pol_o_next   = ~inv; // RULE_06
        valid_n_next = 1'b0;
        taken_next   = 1'b1;
      end else begin
        occ_oe_next  = 1'b0; // RULE_01
        dat_oe_next  = 1'b0;
        dat_o_next   = BUS_IDLE;
        prev_next    = BUS_IDLE;
        pol_o_next   = FLAG_IDLE;
        valid_n_next = 1'b1;
      end
      ooo_n_next = ~out_of_order_flag_n_req; // RULE_03 RULE_04
      dtak_next  = out_of_order_flag_n_req;
      if (cpu_word) begin
        rxv_next = 1'b1;
        rxd_next = dat_s ^ hbd_expand(~pol_s); // RULE_05
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sync1_reg     <= '1;
      sync2_reg     <= '1;
      sync3_occ_reg <= 1'b1;
      div_reg       <= DIV_ZERO;
      bclk_reg      <= 1'b0;
      state_reg     <= ST_IDLE;
      prev_reg      <= BUS_IDLE;
      occ_oe_reg    <= 1'b0;
      dat_o_reg     <= BUS_IDLE;
      dat_oe_reg    <= 1'b0;
      pol_o_reg     <= FLAG_IDLE;
      valid_n_reg   <= 1'b1;
      ooo_n_reg     <= 1'b1;
      taken_reg     <= 1'b0;
      dtak_reg      <= 1'b0;
      rxv_reg       <= 1'b0;
      rxd_reg       <= '0;
    end else begin
      sync1_reg     <= {link.data_bus_occupied_n, link.cpu_valid_n, link.group_polarity_flag_n, link.data_line};
      sync2_reg     <= sync1_reg;
      sync3_occ_reg <= sync2_reg[SYNC_W-3] | occ_oe_reg;
      div_reg       <= div_next;
      bclk_reg      <= bclk_next;
      state_reg     <= state_next;
      prev_reg      <= prev_next;
      occ_oe_reg    <= occ_oe_next;
      dat_o_reg     <= dat_o_next;
      dat_oe_reg    <= dat_oe_next;
      pol_o_reg     <= pol_o_next;
      valid_n_reg   <= valid_n_next;
      ooo_n_reg     <= ooo_n_next;
      taken_reg     <= taken_next;
      dtak_reg      <= dtak_next;
      rxv_reg       <= rxv_next;
      rxd_reg       <= rxd_next;
    end
  end

  assign link.bus_clk             = bclk_reg;
  assign link.occ_hub_o           = 1'b0;
  assign link.occ_hub_oe          = occ_oe_reg;
  assign link.dat_hub_o           = dat_o_reg;
  assign link.dat_hub_oe          = dat_oe_reg;
  assign link.pol_hub_o           = pol_o_reg;
  assign link.hub_valid_n         = valid_n_reg;
  assign link.out_of_order_flag_n = ooo_n_reg;
  assign tx_taken                 = taken_reg;
  assign out_of_order_flag_n_taken              = dtak_reg;
  assign rx_valid                 = rxv_reg;
  assign rx_data                  = rxd_reg;

endmodule : hbd_hub_end

/* File: verif/hbd_link_chk.sv */
// Checker on the data phase link between processor end and hub end.
// Assumes one shared core clock and reset; inputs are the resolved link signals plus each end's data enable.
module hbd_link_chk (
  input wire logic                       core_clk,
  input wire logic                       nrst,
  input wire logic                       data_bus_occupied_n,
  input wire logic                       dat_cpu_oe,
  input wire logic                       dat_hub_oe,
  input wire logic [hbd_pkg::DATA_W-1:0] data_line,
  input wire logic [hbd_pkg::GROUPS-1:0] group_polarity_flag_n,
  input wire logic                       cpu_valid_n,
  input wire logic                       out_of_order_flag_n
);
  import hbd_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  // Each group flagged exactly when its plain value would toggle more than half its lines
  function automatic logic inv_ok(input logic [DATA_W-1:0] prev, input logic [DATA_W-1:0] line,
                                  input logic [GROUPS-1:0] fl);
    logic               ok;
    logic [GROUP_W-1:0] lg;
    ok = 1'b1;
    for (int g = 0; g < GROUPS; g++) begin
      lg = line[g*GROUP_W +: GROUP_W] ^ {GROUP_W{~fl[g]}};
      ok = ok & (~fl[g] == ($countones(lg ^ prev[g*GROUP_W +: GROUP_W]) > 8));
    end
    return ok;
  endfunction : inv_ok

  cpu_busy_held_a: assert property (dat_cpu_oe |-> !data_bus_occupied_n)
    else $error("busy not held by processor end");
  hub_busy_held_a: assert property (dat_hub_oe |-> !data_bus_occupied_n)
    else $error("busy not held by hub end");
  word_busy_len_a: assert property ($fell(cpu_valid_n) |-> (!cpu_valid_n && !data_bus_occupied_n) [*8])
    else $error("processor word shorter than a bus period");
  no_overlap_a: assert property (!(dat_cpu_oe && dat_hub_oe))
    else $error("both ends drive data");
  cpu_start_free_a: assert property ($rose(dat_cpu_oe) |-> $past(data_bus_occupied_n, 2))
    else $error("processor end started on a busy bus");
  cpu_inv_a: assert property (
    dat_cpu_oe && $changed(data_line) |-> inv_ok($past(data_line), data_line, group_polarity_flag_n))
    else $error("processor group inversion wrong");
  hub_inv_a: assert property (
    dat_hub_oe && $changed(data_line) |-> inv_ok($past(data_line), data_line, group_polarity_flag_n))
    else $error("hub group inversion wrong");
  out_of_order_flag_n_len_a: assert property (
    $fell(out_of_order_flag_n) |-> !out_of_order_flag_n [*8] ##1 out_of_order_flag_n)
    else $error("out of order flag not one bus period");
endmodule : hbd_link_chk

/* File: verif/tb_top.sv */
// Bench joining the processor end and the hub end through the link interface.
// Assumes package, interface, both ends and the link checker are compiled first.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import hbd_pkg::*;
  logic              core_clk, nrst, c_vld, h_vld, out_of_order_flag_n_req;
  logic              c_tkn, c_rv, c_def, c_pend, h_tkn, h_dtk, h_rv;
  logic [DATA_W-1:0] c_dat, h_dat, c_rd, h_rd;
  logic [DATA_W-1:0] to_hub_q[$], to_cpu_q[$];
  logic              def_q[$];
  logic [31:0]       rnd;
  int                fails, samples_checked;

  hbd_link_if hbd_link_if_i ();
  hbd_cpu_end hbd_cpu_end_i (.core_clk(core_clk), .nrst(nrst), .link(hbd_link_if_i.cpu), .tx_valid(c_vld),
    .tx_data(c_dat), .tx_taken(c_tkn), .rx_valid(c_rv), .rx_data(c_rd), .deferred(c_def), .deferred_pending(c_pend));
  hbd_hub_end hbd_hub_end_i (.core_clk(core_clk), .nrst(nrst), .link(hbd_link_if_i.hub), .tx_valid(h_vld),
    .tx_data(h_dat), .tx_taken(h_tkn), .out_of_order_flag_n_req(out_of_order_flag_n_req), .out_of_order_flag_n_taken(h_dtk), .rx_valid(h_rv), .rx_data(h_rd));
  hbd_link_chk hbd_link_chk_i (.core_clk(core_clk), .nrst(nrst),
    .data_bus_occupied_n(hbd_link_if_i.data_bus_occupied_n), .dat_cpu_oe(hbd_link_if_i.dat_cpu_oe),
    .dat_hub_oe(hbd_link_if_i.dat_hub_oe), .data_line(hbd_link_if_i.data_line),
    .group_polarity_flag_n(hbd_link_if_i.group_polarity_flag_n), .cpu_valid_n(hbd_link_if_i.cpu_valid_n),
    .out_of_order_flag_n(hbd_link_if_i.out_of_order_flag_n));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h0400_0007 : 32'h0000_0000);
  endfunction : lfsr

  function automatic logic [DATA_W-1:0] rword();
    rnd = lfsr(rnd);
    rword[31:0] = rnd;
    rnd = lfsr(rnd);
    rword[63:32] = rnd;
  endfunction : rword

  task automatic cmp_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp_word

  task automatic cmp_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp_bit

  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (s !== 1'b1 && n < 400);
    if (s !== 1'b1) fails++;
  endtask : wait_hi

  // Offer one word and note it for the far end; returns at the negedge that shows tx_taken
  task automatic send(input logic hub, input logic [DATA_W-1:0] w);
    if (hub) begin
      h_vld = 1'b1;
      h_dat = w;
      to_cpu_q.push_back(w);
      wait_hi(h_tkn);
    end else begin
      c_vld = 1'b1;
      c_dat = w;
      to_hub_q.push_back(w);
      wait_hi(c_tkn);
    end
  endtask : send

  task automatic burst(input logic hub, input int n, input logic [DATA_W-1:0] first);
    send(hub, first);
    for (int i = 1; i < n; i++) send(hub, rword());
    if (hub) h_vld = 1'b0;
    else c_vld = 1'b0;
  endtask : burst

  task automatic drain(input string name);
    int n;
    n = 0;
    while (to_hub_q.size() + to_cpu_q.size() + def_q.size() != 0 && n < 400) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 400) fails++;
    wait_hi(hbd_link_if_i.data_bus_occupied_n);
    repeat (16) @(negedge core_clk);
    $display("test %s done", name);
  endtask : drain

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  always @(negedge core_clk) begin
    if (h_rv === 1'b1) cmp_word(h_rd, to_hub_q.pop_front());
    if (c_rv === 1'b1) cmp_word(c_rd, to_cpu_q.pop_front());
    if (c_def === 1'b1) cmp_bit(c_pend, def_q.pop_front());
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    close_out();
  end

  initial begin
    nrst = 1'b0;
    c_vld = 1'b0;
    h_vld = 1'b0;
    out_of_order_flag_n_req = 1'b0;
    c_dat = '0;
    h_dat = '0;
    rnd = 32'h003c;
    fails = 0;
    samples_checked = 0;
    repeat (4) @(negedge core_clk);
    nrst = 1'b1;
    burst(1'b0, 6, 64'hffff_0000_007f_00ff);
    drain("cpu boundary burst");
    burst(1'b1, 5, 64'h0000_0000_0000_0000);
    drain("hub full inversion burst");
    for (int k = 0; k < 4; k++) begin
      burst(k[0], 4, rword());
      drain("random burst");
    end
    out_of_order_flag_n_req = 1'b1;
    def_q.push_back(1'b1);
    wait_hi(h_dtk);
    out_of_order_flag_n_req = 1'b0;
    drain("out_of_order_flag_n");
    cmp_bit(c_pend, 1'b1);
    burst(1'b1, 1, rword());
    drain("later completion");
    cmp_bit(c_pend, 1'b0);
    fork
      burst(1'b1, 4, rword());
      begin
        repeat (20) @(negedge core_clk);
        burst(1'b0, 2, rword());
      end
    join
    drain("busy refusal");
    close_out();
  end
endmodule : tb_top
